// [rwd_regs.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes a 25 MHz system clock and 8-bit APB byte addresses.
`ifndef RWD_REGS_SVH
`define RWD_REGS_SVH
`define RWD_OFS_CTRL 8'h00
`define RWD_OFS_DELAY 8'h04
`define RWD_OFS_TMO1 8'h08
`define RWD_OFS_TMO2 8'h0C
`define RWD_OFS_KICK 8'h10
`define RWD_OFS_STATE 8'h14
`define RWD_OFS_ISTAT 8'h18
`define RWD_OFS_IMASK 8'h1C
`define RWD_OFS_COUNT 8'h20
`define RWD_CTRL_MODE_LSB 0
`define RWD_CTRL_EV1_LSB 2
`define RWD_CTRL_EV2_BIT 4
`define RWD_CTRL_ARM_BIT 8
`define RWD_CTRL_RST 32'h0000_0000
`define RWD_DELAY_RST 32'h0000_03E8
`define RWD_TMO1_RST 32'h0000_03E8
`define RWD_TMO2_RST 32'h0000_03E8
`define RWD_IMASK_RST 3'h0
`define RWD_IRQ_EV1_BIT 0
`define RWD_IRQ_EV2_BIT 1
`define RWD_IRQ_OFF_BIT 2
`define RWD_CLK_KHZ 25000
`define RWD_TICK_US 10
`define RWD_TICK_CYC ((`RWD_TICK_US * `RWD_CLK_KHZ) / 1000)
`endif

// [rwd_pkg.sv]
// Types shared by the runtime watchdog.
// Assumes the constants of rwd_regs.svh.
package rwd_pkg;
    typedef enum logic [1:0] {
        RWD_MODE_OFF = 2'h0,
        RWD_MODE_ONCE = 2'h1,
        RWD_MODE_SINGLE = 2'h2,
        RWD_MODE_REPEAT = 2'h3
    } rwd_mode_e;
    typedef enum logic [1:0] {
        RWD_EV1_NMI = 2'h0,
        RWD_EV1_RESET = 2'h1,
        RWD_EV1_PWRBTN = 2'h2,
        RWD_EV1_ACPI = 2'h3
    } rwd_ev1_e;
    typedef enum logic [4:0] {
        RWD_ST_IDLE = 5'h01,
        RWD_ST_DELAY = 5'h02,
        RWD_ST_STAGE1 = 5'h04,
        RWD_ST_STAGE2 = 5'h08,
        RWD_ST_REPEAT = 5'h10
    } rwd_state_e;
endpackage

// [rwd_watchdog.sv]
// Two-stage runtime watchdog with an APB register slave.
// Assumes one 25 MHz clock, synchronous APB inputs and asynchronous reset.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "rwd_regs.svh"

// Operation
// - In one-time-trigger mode the first trigger disables the watchdog.
// - In single-event mode each stage runs once, then the watchdog disables.
// - In repeated-event mode the last stage reruns until a system reset.
// - Once started the watchdog waits the selected delay before timing.
// - First-stage expiry raises the selected NMI, reset, button or ACPI event.
// - Second-stage expiry raises nothing or an NMI, as selected.
// - The mode is configurable as disabled or one of three active modes.
// - The watchdog is armed just before OS boot; its delay counts from there.
module rwd_watchdog
    import rwd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic nmi_out,
    output logic sys_reset_out,
    output logic pwr_button_out,
    output logic acpi_event_out,
    output logic irq
);
    localparam logic [15:0] TICK_CYC = 16'(`RWD_TICK_CYC);

    logic [31:0] ctrl_reg;
    logic [31:0] delay_reg;
    logic [31:0] tmo1_reg;
    logic [31:0] tmo2_reg;
    logic [2:0] istat_reg;
    logic [2:0] imask_reg;
    logic [31:0] count_reg;
    logic [15:0] div_reg;
    logic tick;
    rwd_state_e state_reg;
    rwd_mode_e mode;
    rwd_ev1_e ev1_sel;
    logic ev2_en;
    logic setup;
    logic wr_en;
    logic mapped;
    logic arm;
    logic kick;
    logic expire;
    logic ev1_fire;
    logic ev2_fire;
    logic off_fire;

    assign mode = rwd_mode_e'(ctrl_reg[`RWD_CTRL_MODE_LSB +: 2]);
    assign ev1_sel = rwd_ev1_e'(ctrl_reg[`RWD_CTRL_EV1_LSB +: 2]);
    assign ev2_en = ctrl_reg[`RWD_CTRL_EV2_BIT];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    always_comb
    begin
        unique case (paddr)
            `RWD_OFS_CTRL, `RWD_OFS_DELAY, `RWD_OFS_TMO1, `RWD_OFS_TMO2,
            `RWD_OFS_KICK, `RWD_OFS_STATE, `RWD_OFS_ISTAT, `RWD_OFS_IMASK,
            `RWD_OFS_COUNT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;
    // Writing the arm bit starts the watchdog from idle when the mode already held in the control register is not off, just before OS boot.
    assign arm = wr_en && paddr == `RWD_OFS_CTRL
        && pwdata[`RWD_CTRL_ARM_BIT];
    assign kick = wr_en && paddr == `RWD_OFS_KICK;
    assign expire = tick && count_reg == 32'h0000_0000;
    assign irq = |(istat_reg & imask_reg);

    // Prescaler giving one tick every ten microseconds.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            div_reg <= 16'h0000;
        else if (div_reg == TICK_CYC - 16'h0001)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    assign tick = div_reg == TICK_CYC - 16'h0001;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= `RWD_CTRL_RST;
            delay_reg <= `RWD_DELAY_RST;
            tmo1_reg <= `RWD_TMO1_RST;
            tmo2_reg <= `RWD_TMO2_RST;
            imask_reg <= `RWD_IMASK_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `RWD_OFS_CTRL: ctrl_reg <= {27'h0, pwdata[4:0]};
                `RWD_OFS_DELAY: delay_reg <= pwdata;
                `RWD_OFS_TMO1: tmo1_reg <= pwdata;
                `RWD_OFS_TMO2: tmo2_reg <= pwdata;
                `RWD_OFS_IMASK: imask_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Stage sequencer.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= RWD_ST_IDLE;
            count_reg <= 32'h0000_0000;
        end
        else
        begin
            unique case (state_reg)
                RWD_ST_IDLE:
                begin
                    if (arm && mode != RWD_MODE_OFF)
                    begin
                        state_reg <= RWD_ST_DELAY;
                        count_reg <= delay_reg;
                    end
                end
                RWD_ST_DELAY:
                begin
                    if (expire)
                    begin
                        state_reg <= RWD_ST_STAGE1;
                        count_reg <= tmo1_reg;
                    end
                    else if (tick)
                        count_reg <= count_reg - 32'h0000_0001;
                end
                RWD_ST_STAGE1, RWD_ST_STAGE2:
                begin
                    if (kick && mode == RWD_MODE_ONCE)
                        state_reg <= RWD_ST_IDLE;
                    else if (kick)
                    begin
                        state_reg <= RWD_ST_STAGE1;
                        count_reg <= tmo1_reg;
                    end
                    else if (expire && state_reg == RWD_ST_STAGE1)
                    begin
                        state_reg <= RWD_ST_STAGE2;
                        count_reg <= tmo2_reg;
                    end
                    else if (expire && mode == RWD_MODE_REPEAT)
                    begin
                        state_reg <= RWD_ST_REPEAT;
                        count_reg <= tmo2_reg;
                    end
                    else if (expire)
                        state_reg <= RWD_ST_IDLE;
                    else if (tick)
                        count_reg <= count_reg - 32'h0000_0001;
                end
                RWD_ST_REPEAT:
                begin
                    if (expire)
                        count_reg <= tmo2_reg;
                    else if (tick)
                        count_reg <= count_reg - 32'h0000_0001;
                end
            endcase
        end
    end

    assign ev1_fire = expire && state_reg == RWD_ST_STAGE1 && !kick;
    assign ev2_fire = expire && !kick
        && (state_reg == RWD_ST_STAGE2 || state_reg == RWD_ST_REPEAT);
    assign off_fire = (state_reg == RWD_ST_STAGE1
        || state_reg == RWD_ST_STAGE2)
        && ((kick && mode == RWD_MODE_ONCE)
        || (ev2_fire && mode != RWD_MODE_REPEAT));

    // Event outputs, one clock pulse each.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_out <= 1'b0;
            sys_reset_out <= 1'b0;
            pwr_button_out <= 1'b0;
            acpi_event_out <= 1'b0;
        end
        else
        begin
            nmi_out <= (ev1_fire && ev1_sel == RWD_EV1_NMI)
                || (ev2_fire && ev2_en);
            sys_reset_out <= ev1_fire && ev1_sel == RWD_EV1_RESET;
            pwr_button_out <= ev1_fire && ev1_sel == RWD_EV1_PWRBTN;
            acpi_event_out <= ev1_fire && ev1_sel == RWD_EV1_ACPI;
        end
    end

    // Sticky interrupt status; a new event wins over a clearing write.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            istat_reg <= 3'h0;
        else
            istat_reg <= (istat_reg
                & ~((wr_en && paddr == `RWD_OFS_ISTAT) ? pwdata[2:0] : 3'h0))
                | {off_fire, ev2_fire, ev1_fire};
    end

    // Read data is captured in the setup cycle.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            unique case (paddr)
                `RWD_OFS_CTRL: prdata <= ctrl_reg;
                `RWD_OFS_DELAY: prdata <= delay_reg;
                `RWD_OFS_TMO1: prdata <= tmo1_reg;
                `RWD_OFS_TMO2: prdata <= tmo2_reg;
                `RWD_OFS_STATE: prdata <= {27'h0, state_reg};
                `RWD_OFS_ISTAT: prdata <= {29'h0, istat_reg};
                `RWD_OFS_IMASK: prdata <= {29'h0, imask_reg};
                `RWD_OFS_COUNT: prdata <= count_reg;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [rwd_watchdog_monitor.sv]
// Checker for the watchdog's bus and event ports.
// Assumes it is bound onto rwd_watchdog with one clock domain.
`timescale 1ns/1ns
module rwd_watchdog_monitor
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nmi_out,
    input wire logic sys_reset_out,
    input wire logic pwr_button_out,
    input wire logic acpi_event_out,
    input wire logic irq
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire logic acc = psel && penable;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc && paddr > 8'h20 |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property
        (acc && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    a_rd_unmapped: assert property
        (acc && !pwrite && paddr > 8'h20 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ev_onehot: assert property
        ($onehot0({nmi_out, sys_reset_out, pwr_button_out, acpi_event_out}))
        else $error("events overlap");
    a_sys_pulse: assert property (sys_reset_out |=> !sys_reset_out)
        else $error("reset event too long");
    a_nmi_pulse: assert property ($rose(nmi_out) |=> $fell(nmi_out))
        else $error("nmi too long");
    a_acpi_gap: assert property (acpi_event_out |=> !nmi_out [*8])
        else $error("second event too soon");
    a_irq_masked: assert property (acc && pwrite && paddr == 8'h1C
        && pwdata[2:0] == 3'h0 |=> !irq)
        else $error("masked irq high");
    cover property (acpi_event_out);
    cover property (nmi_out);
    cover property (acc && pslverr);
    cover property (pwr_button_out);
endmodule
bind rwd_watchdog rwd_watchdog_monitor i_rwd_watchdog_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_out(nmi_out), .irq(irq),
    .sys_reset_out(sys_reset_out), .pwr_button_out(pwr_button_out),
    .acpi_event_out(acpi_event_out));

// [rwd_host.sv]
// Host model that reaches the watchdog over APB and triggers it.
// Assumes a zero or multi wait APB slave on the same clock.
`timescale 1ns/1ns
module rwd_host
(
    input wire logic sys_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic kick();
        logic [31:0] q;
        logic e;
        xfer(1'b1, 8'h10, 32'h0, q, e);
    endtask
endmodule

// [rwd_watchdog_bench.sv]
// Self-checking bench for the runtime watchdog.
// Assumes the host model drives APB and the checker is bound.
`timescale 1ns/1ns
`include "rwd_regs.svh"
module rwd_watchdog_bench
    import rwd_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;
        logic [31:0] x; logic err;} rwd_row_s;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic nmi_out, sys_reset_out, pwr_button_out, acpi_event_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int evn [4] = '{0, 0, 0, 0};
    int error_cnt = 0;
    int cmp_count = 0;
    rwd_row_s rows [15] = '{'{0, 8'h00, 0, `RWD_CTRL_RST, 0},
        '{0, 8'h04, 0, `RWD_DELAY_RST, 0}, '{0, 8'h08, 0, `RWD_TMO1_RST, 0},
        '{0, 8'h0C, 0, `RWD_TMO2_RST, 0}, '{0, 8'h14, 0, 32'h1, 0},
        '{0, 8'h18, 0, 0, 0}, '{0, 8'h1C, 0, 0, 0}, '{0, 8'h20, 0, 0, 0},
        '{0, 8'h24, 0, 0, 1},
        '{1, 8'h24, 5, 0, 1}, '{1, 8'h04, 0, 0, 0}, '{1, 8'h08, 0, 0, 0},
        '{1, 8'h0C, 0, 0, 0}, '{1, 8'h1C, 7, 0, 0}, '{0, 8'h04, 0, 0, 0}};
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (!reset_n)
            evn = '{0, 0, 0, 0};
        else
        begin
            evn[0] += nmi_out;
            evn[1] += sys_reset_out;
            evn[2] += pwr_button_out;
            evn[3] += acpi_event_out;
        end
    end
    rwd_host i_rwd_host (.sys_clk(sys_clk), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    rwd_watchdog i_rwd_watchdog (.sys_clk(sys_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_out(nmi_out), .irq(irq),
        .sys_reset_out(sys_reset_out), .pwr_button_out(pwr_button_out),
        .acpi_event_out(acpi_event_out));
    task automatic chk(input logic [31:0] a, input logic [31:0] b);
        cmp_count++;
        if (a !== b)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, a, b);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        i_rwd_host.xfer(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_rwd_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic wait_st(input logic [31:0] s);
        q = '1;
        for (int n = 0; n < 500 && q !== s; n++)
            i_rwd_host.xfer(1'b0, `RWD_OFS_STATE, 32'h0, q, e);
        chk(q, s);
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #1_000_000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            i_rwd_host.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
            if (!rows[i].w) chk(q, rows[i].x);
            chk({31'h0, e}, {31'h0, rows[i].err});
        end
        $display("Register table done");
        wr(`RWD_OFS_CTRL, 32'h0000_0001);
        wr(`RWD_OFS_CTRL, 32'h0000_0101);
        rd(`RWD_OFS_STATE, RWD_ST_DELAY);
        wait_st(RWD_ST_STAGE1);
        i_rwd_host.kick();
        rd(`RWD_OFS_STATE, RWD_ST_IDLE);
        rd(`RWD_OFS_ISTAT, 32'h4);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`RWD_OFS_ISTAT, 32'h4);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        chk(evn[0] + evn[1] + evn[2] + evn[3], 0);
        $display("One time trigger done");
        wr(`RWD_OFS_CTRL, 32'h0000_001F);
        wr(`RWD_OFS_CTRL, 32'h0000_011F);
        wait_st(RWD_ST_REPEAT);
        chk(evn[3], 1);
        chk(evn[0], 1);
        chk(evn[1] + evn[2], 0);
        i_rwd_host.kick();
        rd(`RWD_OFS_STATE, RWD_ST_REPEAT);
        rd(`RWD_OFS_ISTAT, 32'h3);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`RWD_OFS_STATE, RWD_ST_IDLE);
        rd(`RWD_OFS_ISTAT, 32'h0);
        $display("Repeated event done");
        wr(`RWD_OFS_CTRL, 32'h0000_0100);
        rd(`RWD_OFS_STATE, RWD_ST_IDLE);
        wr(`RWD_OFS_DELAY, 32'h0);
        wr(`RWD_OFS_TMO1, 32'h0);
        wr(`RWD_OFS_TMO2, 32'h0);
        wr(`RWD_OFS_CTRL, 32'h0000_0006);
        wr(`RWD_OFS_CTRL, 32'h0000_0106);
        wait_st(RWD_ST_STAGE2);
        chk(evn[1], 1);
        wait_st(RWD_ST_IDLE);
        chk(evn[0], 0);
        rd(`RWD_OFS_ISTAT, 32'h7);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(`RWD_OFS_IMASK, 32'h1);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`RWD_OFS_IMASK, 32'h0);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(`RWD_OFS_ISTAT, 32'h7);
        repeat (600) @(posedge sys_clk);
        rd(`RWD_OFS_STATE, RWD_ST_IDLE);
        chk(evn[0] + evn[1] + evn[2] + evn[3], 1);
        $display("Single event done");
        wr(`RWD_OFS_TMO1, 32'h2);
        wr(`RWD_OFS_CTRL, 32'h0000_000A);
        wr(`RWD_OFS_CTRL, 32'h0000_010A);
        wait_st(RWD_ST_STAGE1);
        repeat (8)
        begin
            repeat (100) @(posedge sys_clk);
            i_rwd_host.kick();
        end
        rd(`RWD_OFS_STATE, RWD_ST_STAGE1);
        chk(evn[2], 0);
        wait_st(RWD_ST_STAGE2);
        chk(evn[2], 1);
        i_rwd_host.kick();
        rd(`RWD_OFS_STATE, RWD_ST_STAGE1);
        wr(`RWD_OFS_CTRL, 32'h0000_0002);
        wait_st(RWD_ST_STAGE2);
        chk(evn[0], 1);
        wait_st(RWD_ST_IDLE);
        chk(evn[0], 1);
        rd(`RWD_OFS_ISTAT, 32'h7);
        $display("Trigger restart done");
        wrap_up();
    end
endmodule
